// ### logic/tmr_map.svh
/*
 * Register indices, field positions, reset values and codes of the
 * 16-bit timer/event counter.
 * Assumes the includer wants definitions only; byte address = 4 * index.
 */
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH

// Register indices (byte address on APB is four times the index)
`define TMR_IDX_RUN       16'h1180
`define TMR_IDX_MODE      16'h1182
`define TMR_IDX_FFCR      16'h1183
`define TMR_IDX_CMP0_LO   16'h1188
`define TMR_IDX_CMP0_HI   16'h1189
`define TMR_IDX_CMP1_LO   16'h118a
`define TMR_IDX_CMP1_HI   16'h118b
`define TMR_IDX_CAP0_LO   16'h118c
`define TMR_IDX_CAP0_HI   16'h118d
`define TMR_IDX_CAP1_LO   16'h118e
`define TMR_IDX_CAP1_HI   16'h118f
`define TMR_IDX_IRQ_STAT  16'h1190
`define TMR_IDX_IRQ_MASK  16'h1191

// Run register fields
`define TMR_RUN_CNT_BIT   0
`define TMR_RUN_PRE_BIT   2
`define TMR_RUN_DBUF_BIT  7

// Mode register fields
`define TMR_MODE_CLK_LSB  0
`define TMR_MODE_CLE_BIT  2
`define TMR_MODE_CAP1_BIT 4
`define TMR_MODE_CAP0_BIT 5

// Flip-flop control fields and commands
`define TMR_FF_CMD_LSB    0
`define TMR_FF_M0_BIT     2
`define TMR_FF_M1_BIT     3
`define TMR_FF_CAP0_BIT   4
`define TMR_FF_INVERT     2'h0
`define TMR_FF_SET        2'h1
`define TMR_FF_CLEAR      2'h2

// Count clock selections
`define TMR_CLK_STOP      2'h0
`define TMR_CLK_DIV2      2'h1
`define TMR_CLK_DIV8      2'h2
`define TMR_CLK_DIV32     2'h3

// Interrupt bit positions
`define TMR_IRQ_OVF_BIT   0
`define TMR_IRQ_M0_BIT    1
`define TMR_IRQ_M1_BIT    2

// Reset values and timing counts
`define TMR_RST_BYTE      8'h00
`define TMR_RST_WORD      16'h0000
`define TMR_RST_MODE      8'h30
`define TMR_BASE_DIV      8
`define TMR_PRE_BITS      5

`endif

// ### logic/tmr_pkg.sv
/*
 * Types shared by the timer files.
 * Assumes tmr_map.svh supplies the numeric layout.
 */
package tmr_pkg;

    // Run register contents
    typedef struct packed {
        logic dbuf_en;
        logic pre_run;
        logic cnt_run;
    } tmr_run_t;

    // Mode register contents
    typedef struct packed {
        logic       cap0_bit;
        logic       cap1_bit;
        logic       clear_en;
        logic [1:0] clk_sel;
    } tmr_mode_t;

    // Flip-flop inversion enables
    typedef struct packed {
        logic inv_cap0;
        logic inv_m1;
        logic inv_m0;
    } tmr_ffcr_t;

    // Event pulses, in interrupt bit order
    typedef struct packed {
        logic m1;
        logic m0;
        logic ovf;
    } tmr_evt_t;

    // Prescaler tap pulses
    typedef struct packed {
        logic div32;
        logic div8;
        logic div2;
    } tmr_taps_t;

endpackage

// ### logic/tmr_prescaler.sv
/*
 * Divide-by-eight base stage and 5-bit prescaler with three tap pulses.
 * Assumes one clock; taps are one-cycle enables on pclk.
 */
`timescale 1ns/1ps
`include "tmr_map.svh"

module tmr_prescaler #(
    parameter int BASE_DIV = `TMR_BASE_DIV,
    parameter int PRE_BITS = `TMR_PRE_BITS
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              run,
    output tmr_pkg::tmr_taps_t     taps
);
    localparam int BW = $clog2(BASE_DIV);

    logic [BW-1:0]       base_cnt;
    logic [PRE_BITS-1:0] pre_cnt;
    logic                base_tick;

    // One pulse every BASE_DIV peripheral clocks
    assign base_tick = run && (base_cnt == BW'(BASE_DIV - 1));

    // Base divider, cleared while stopped so restarts are aligned
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_cnt <= '0;
        end else if (!run) begin
            base_cnt <= '0;
        end else begin
            base_cnt <= base_tick ? '0 : base_cnt + 1'b1;
        end
    end

    // Prescaler proper; a zero run bit stops and clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt <= '0;
        end else if (!run) begin
            pre_cnt <= '0;
        end else if (base_tick) begin
            pre_cnt <= pre_cnt + 1'b1;
        end
    end

    // Taps as enables rather than derived clocks keep one clock tree
    assign taps.div2  = base_tick && (pre_cnt[0] == 1'b1);
    assign taps.div8  = base_tick && (pre_cnt[2:0] == 3'h7);
    assign taps.div32 = base_tick && (pre_cnt == {PRE_BITS{1'b1}});

endmodule

// ### logic/tmr_compare.sv
/*
 * One comparator: counter against a compare register.
 * Assumes tick marks the cycle in which the counter takes a step.
 */
`timescale 1ns/1ps

module tmr_compare #(
    parameter int WIDTH = 16
) (
    input  wire logic [WIDTH-1:0] count,
    input  wire logic [WIDTH-1:0] value,
    input  wire logic             tick,
    output logic                  match
);
    // Match is judged only on a counting step, so a stopped counter
    // sitting on the value does not fire every cycle
    assign match = tick && (count == value);

endmodule

// ### logic/tmr_timer.sv
/*
 * 16-bit timer/event counter with APB register access.
 * Holds the up counter, compare and capture registers, the output
 * flip-flop and the interrupt status and mask.
 * Assumes a zero-wait APB master on pclk and port-select logic that
 * drives port_func_sel, port_data and port_dir synchronously on pclk.
 */
// Register access over APB was decided locally.
// What this block does
// - Same counter serves interval timer, event counter and pulse generator modes
// - One up counter, two compares with one buffered, captures, flip-flop
// - Eleven byte registers sit at their fixed offsets
// - No external clock or capture input; flip-flop leaves via shared port pin
// - Prescaler base is clock divided by eight; taps at 1/2, 1/8, 1/32
// - Prescaler counts with run bit set; clearing it stops and zeroes it
// - Counter steps on selected tap; optional clear on second compare match
// - Overflow interrupt on wrap; match interrupt per comparator
`timescale 1ns/1ps
`include "tmr_map.svh"

module tmr_timer #(
    parameter int ADDR_W = 18,
    parameter int CNT_W  = 16
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    output logic                   irq,
    input  wire logic              port_func_sel,
    input  wire logic              port_data,
    input  wire logic              port_dir,
    output logic                   shared_port_bit,
    output logic                   shared_port_bit_oe
);
    // Mode reset value as a byte, so its fields can be picked by position
    localparam logic [7:0] RST_MODE = `TMR_RST_MODE;

    tmr_pkg::tmr_run_t  run_ctl;
    tmr_pkg::tmr_mode_t mode_ctl;
    tmr_pkg::tmr_ffcr_t ffcr;
    tmr_pkg::tmr_taps_t taps;
    tmr_pkg::tmr_evt_t  evt;
    tmr_pkg::tmr_evt_t  irq_stat;
    tmr_pkg::tmr_evt_t  irq_mask;

    logic [CNT_W-1:0] main_up_counter;
    logic [CNT_W-1:0] compare0;
    logic [CNT_W-1:0] compare0_buf;
    logic [CNT_W-1:0] compare1;
    logic [CNT_W-1:0] capture0;
    logic [CNT_W-1:0] capture1;
    logic             flipflop;
    logic             count_tick;
    logic             match0;
    logic             match1;
    logic             wrap;
    logic             cap0_load;
    logic             cap1_load;
    logic             ff_write;

    logic [15:0]      idx;
    logic             aligned;
    logic             mapped;
    logic             wr_access;
    logic             rd_setup;
    logic             lane0;
    logic [7:0]       wbyte;
    logic [7:0]       next_rdata;

    // APB decode; the word index carries the printed offset
    assign idx       = 16'(paddr[ADDR_W-1:2]);
    assign aligned   = (paddr[1:0] == 2'h0);
    assign wr_access = psel && penable && pwrite && mapped;
    assign rd_setup  = psel && !penable && !pwrite;
    assign lane0     = pstrb[0];
    assign wbyte     = pwdata[7:0];

    // Only the eleven timer bytes and the two interrupt bytes answer
    always_comb begin
        unique case (idx)
            `TMR_IDX_RUN, `TMR_IDX_MODE, `TMR_IDX_FFCR,
            `TMR_IDX_CMP0_LO, `TMR_IDX_CMP0_HI,
            `TMR_IDX_CMP1_LO, `TMR_IDX_CMP1_HI,
            `TMR_IDX_CAP0_LO, `TMR_IDX_CAP0_HI,
            `TMR_IDX_CAP1_LO, `TMR_IDX_CAP1_HI,
            `TMR_IDX_IRQ_STAT, `TMR_IDX_IRQ_MASK: mapped = aligned;
            default: mapped = 1'b0;
        endcase
    end

    // Zero-wait slave; the error only shows in the access phase
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Read data is taken in the setup cycle so prdata comes from a flop
    always_comb begin
        next_rdata = 8'h00;
        unique case (idx)
            `TMR_IDX_RUN: begin
                next_rdata[`TMR_RUN_CNT_BIT]  = run_ctl.cnt_run;
                next_rdata[`TMR_RUN_PRE_BIT]  = run_ctl.pre_run;
                next_rdata[`TMR_RUN_DBUF_BIT] = run_ctl.dbuf_en;
            end
            `TMR_IDX_MODE: begin
                next_rdata[`TMR_MODE_CLK_LSB +: 2] = mode_ctl.clk_sel;
                next_rdata[`TMR_MODE_CLE_BIT]      = mode_ctl.clear_en;
                next_rdata[`TMR_MODE_CAP1_BIT]     = mode_ctl.cap1_bit;
                next_rdata[`TMR_MODE_CAP0_BIT]     = mode_ctl.cap0_bit;
            end
            `TMR_IDX_FFCR: begin
                next_rdata[`TMR_FF_CMD_LSB +: 2] = 2'h3; // Command field reads as no-op
                next_rdata[`TMR_FF_M0_BIT]       = ffcr.inv_m0;
                next_rdata[`TMR_FF_M1_BIT]       = ffcr.inv_m1;
                next_rdata[`TMR_FF_CAP0_BIT]     = ffcr.inv_cap0;
            end
            `TMR_IDX_CAP0_LO:  next_rdata = capture0[7:0];
            `TMR_IDX_CAP0_HI:  next_rdata = capture0[15:8];
            `TMR_IDX_CAP1_LO:  next_rdata = capture1[7:0];
            `TMR_IDX_CAP1_HI:  next_rdata = capture1[15:8];
            `TMR_IDX_IRQ_STAT: next_rdata = {5'h00, irq_stat};
            `TMR_IDX_IRQ_MASK: next_rdata = {5'h00, irq_mask};
            default:           next_rdata = 8'h00; // Compare registers are write-only
        endcase
    end

    // Read data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= {24'h00_0000, mapped ? next_rdata : 8'h00}; // Refused reads show zero
        end
    end

    // Run register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_ctl <= '0;
        end else if (wr_access && lane0 && idx == `TMR_IDX_RUN) begin
            run_ctl.cnt_run <= wbyte[`TMR_RUN_CNT_BIT];
            run_ctl.pre_run <= wbyte[`TMR_RUN_PRE_BIT];
            run_ctl.dbuf_en <= wbyte[`TMR_RUN_DBUF_BIT];
        end
    end

    // Mode register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ctl.clk_sel  <= RST_MODE[`TMR_MODE_CLK_LSB +: 2];
            mode_ctl.clear_en <= RST_MODE[`TMR_MODE_CLE_BIT];
            mode_ctl.cap1_bit <= RST_MODE[`TMR_MODE_CAP1_BIT];
            mode_ctl.cap0_bit <= RST_MODE[`TMR_MODE_CAP0_BIT];
        end else if (wr_access && lane0 && idx == `TMR_IDX_MODE) begin
            mode_ctl.clk_sel  <= wbyte[`TMR_MODE_CLK_LSB +: 2];
            mode_ctl.clear_en <= wbyte[`TMR_MODE_CLE_BIT];
            mode_ctl.cap1_bit <= wbyte[`TMR_MODE_CAP1_BIT];
            mode_ctl.cap0_bit <= wbyte[`TMR_MODE_CAP0_BIT];
        end
    end

    // Flip-flop control enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ffcr <= '0;
        end else if (wr_access && lane0 && idx == `TMR_IDX_FFCR) begin
            ffcr.inv_m0   <= wbyte[`TMR_FF_M0_BIT];
            ffcr.inv_m1   <= wbyte[`TMR_FF_M1_BIT];
            ffcr.inv_cap0 <= wbyte[`TMR_FF_CAP0_BIT];
        end
    end

    // Compare 0 and its shadow: with the buffer off a write lands in both,
    // with it on only the shadow, copied across on a compare 1 match
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare0     <= `TMR_RST_WORD;
            compare0_buf <= `TMR_RST_WORD;
        end else begin
            if (run_ctl.dbuf_en && match1) begin
                compare0 <= compare0_buf;
            end
            if (wr_access && lane0 && idx == `TMR_IDX_CMP0_LO) begin
                compare0_buf[7:0] <= wbyte;
                if (!run_ctl.dbuf_en) begin
                    compare0[7:0] <= wbyte;
                end
            end
            if (wr_access && lane0 && idx == `TMR_IDX_CMP0_HI) begin
                compare0_buf[15:8] <= wbyte;
                if (!run_ctl.dbuf_en) begin
                    compare0[15:8] <= wbyte;
                end
            end
        end
    end

    // Compare 1 has no shadow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare1 <= `TMR_RST_WORD;
        end else if (wr_access && lane0 && idx == `TMR_IDX_CMP1_LO) begin
            compare1[7:0] <= wbyte;
        end else if (wr_access && lane0 && idx == `TMR_IDX_CMP1_HI) begin
            compare1[15:8] <= wbyte;
        end
    end

    // Prescaler and its tap enables
    tmr_prescaler #(
        .BASE_DIV (`TMR_BASE_DIV),
        .PRE_BITS (`TMR_PRE_BITS)
    ) u_prescaler (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (run_ctl.pre_run),
        .taps    (taps)
    );

    // Tap selection; no external clock exists, so code zero stops counting
    always_comb begin
        unique case (mode_ctl.clk_sel)
            `TMR_CLK_DIV2:  count_tick = taps.div2;
            `TMR_CLK_DIV8:  count_tick = taps.div8;
            `TMR_CLK_DIV32: count_tick = taps.div32;
            default:        count_tick = 1'b0;
        endcase
    end

    // Both comparators share one small module
    tmr_compare #(.WIDTH(CNT_W)) u_cmp0 (
        .count (main_up_counter),
        .value (compare0),
        .tick  (count_tick && run_ctl.cnt_run),
        .match (match0)
    );

    tmr_compare #(.WIDTH(CNT_W)) u_cmp1 (
        .count (main_up_counter),
        .value (compare1),
        .tick  (count_tick && run_ctl.cnt_run),
        .match (match1)
    );

    // A wrap only counts when the step is not replaced by a clear
    assign wrap = count_tick && run_ctl.cnt_run && (&main_up_counter)
                  && !(mode_ctl.clear_en && match1);

    // Up counter: interval, event and pulse modes all run on this one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_up_counter <= `TMR_RST_WORD;
        end else if (!run_ctl.cnt_run) begin
            main_up_counter <= `TMR_RST_WORD; // Stop and clear
        end else if (count_tick) begin
            if (mode_ctl.clear_en && match1) begin
                main_up_counter <= `TMR_RST_WORD;
            end else begin
                main_up_counter <= main_up_counter + 1'b1;
            end
        end
    end

    // Writing a capture bit as zero loads, and so does writing one over a zero;
    // the capture needs the prescaler running
    assign cap0_load = wr_access && lane0 && idx == `TMR_IDX_MODE && run_ctl.pre_run
                       && (!wbyte[`TMR_MODE_CAP0_BIT] || !mode_ctl.cap0_bit);
    assign cap1_load = wr_access && lane0 && idx == `TMR_IDX_MODE && run_ctl.pre_run
                       && (!wbyte[`TMR_MODE_CAP1_BIT] || !mode_ctl.cap1_bit);

    // Capture registers, loaded only by software; no trigger pin exists
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture0 <= `TMR_RST_WORD;
            capture1 <= `TMR_RST_WORD;
        end else begin
            if (cap0_load) begin
                capture0 <= main_up_counter;
            end
            if (cap1_load) begin
                capture1 <= main_up_counter;
            end
        end
    end

    // Output flip-flop; a software command wins over a same-cycle toggle
    assign ff_write = wr_access && lane0 && idx == `TMR_IDX_FFCR;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flipflop <= 1'b0;
        end else if (ff_write && wbyte[`TMR_FF_CMD_LSB +: 2] == `TMR_FF_INVERT) begin
            flipflop <= !flipflop;
        end else if (ff_write && wbyte[`TMR_FF_CMD_LSB +: 2] == `TMR_FF_SET) begin
            flipflop <= 1'b1;
        end else if (ff_write && wbyte[`TMR_FF_CMD_LSB +: 2] == `TMR_FF_CLEAR) begin
            flipflop <= 1'b0;
        end else if ((match0 && ffcr.inv_m0) ^ (match1 && ffcr.inv_m1)
                     ^ (cap0_load && ffcr.inv_cap0)) begin
            flipflop <= !flipflop; // Pulse generation toggles on each enabled match; two in one cycle cancel
        end
    end

    // Shared port bit: timer output when selected, plain port data otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shared_port_bit    <= 1'b0;
            shared_port_bit_oe <= 1'b0;
        end else begin
            shared_port_bit    <= port_func_sel ? flipflop : port_data;
            shared_port_bit_oe <= port_func_sel | port_dir;
        end
    end

    // Event pulses in interrupt bit order
    assign evt.ovf = wrap;
    assign evt.m0  = match0;
    assign evt.m1  = match1;

    // Sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= '0;
        end else if (wr_access && lane0 && idx == `TMR_IDX_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~tmr_pkg::tmr_evt_t'(wbyte[2:0])) | evt;
        end else begin
            irq_stat <= irq_stat | evt;
        end
    end

    // Interrupt mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= '0;
        end else if (wr_access && lane0 && idx == `TMR_IDX_IRQ_MASK) begin
            irq_mask <= tmr_pkg::tmr_evt_t'(wbyte[2:0]);
        end
    end

    // Level interrupt while any unmasked status bit stands
    assign irq = |(irq_stat & irq_mask);

endmodule

// ### sim/tmr_timer_sva.sv
/* Port checker for tmr_timer: bus answers, error decode, pin routing.
   Assumes it is bound to tmr_timer and sees only its ports. */
`timescale 1ns/1ps
module tmr_timer_sva #(
    parameter int ADDR_W = 18
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic              pready,
    input wire logic [31:0]       prdata,
    input wire logic              pslverr,
    input wire logic              irq,
    input wire logic              port_func_sel,
    input wire logic              port_data,
    input wire logic              port_dir,
    input wire logic              shared_port_bit,
    input wire logic              shared_port_bit_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic ff_set;
    // Access phase and a set command to the flip-flop
    assign acc = psel && penable;
    assign ff_set = acc && pwrite && pstrb[0] && paddr == 18'h0460c && pwdata[1:0] == 2'h1;
    ready_const_a: assert property (pready)
        else $error("pready low");
    err_phase_a: assert property (pslverr |-> acc)
        else $error("pslverr outside access");
    err_align_a: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access accepted");
    err_range_a: assert property (acc && paddr[ADDR_W-1:2] > 16'h1191 |-> pslverr)
        else $error("unmapped access accepted");
    err_rdata_a: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("unmapped read returned data");
    // Read data may only move at a read setup edge
    rdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("prdata moved without read");
    rdata_width_a: assert property (prdata[31:8] == 24'h0)
        else $error("prdata upper bits set");
    oe_follow_a: assert property (1'b1 |=> shared_port_bit_oe == ($past(port_func_sel) || $past(port_dir)))
        else $error("pin enable wrong");
    pin_data_a: assert property (!port_func_sel |=> shared_port_bit == $past(port_data))
        else $error("pin data wrong");
    ff_set_pin_a: assert property (ff_set ##1 port_func_sel |=> shared_port_bit)
        else $error("set command not on pin");
    cover property (acc && pslverr);
    cover property ($rose(irq));
    cover property (port_func_sel && shared_port_bit);
endmodule
bind tmr_timer tmr_timer_sva #(.ADDR_W(ADDR_W)) u_sva (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .irq, .port_func_sel,
    .port_data, .port_dir, .shared_port_bit, .shared_port_bit_oe);

// ### sim/tmr_timer_tb.sv
/* Self-checking bench for tmr_timer: registers, taps, interrupts, pin.
   Assumes the zero-wait APB slave and registered pin outputs of the design. */
`timescale 1ns/1ps
`include "tmr_map.svh"
module tmr_timer_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic        port_func_sel, port_data, port_dir, shared_port_bit, shared_port_bit_oe;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic [7:0]  rd;
    logic        err;
    int          num_errors, compares, cycles;

    tmr_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .irq(irq), .port_func_sel(port_func_sel),
        .port_data(port_data), .port_dir(port_dir), .shared_port_bit(shared_port_bit),
        .shared_port_bit_oe(shared_port_bit_oe));

    // 40 MHz clock
    always #12.5 pclk = ~pclk;

    // Hang guard, far above the roughly 1200 cycles the tests need
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            test_done();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        if (num_errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // One APB transfer; the leading edge keeps back-to-back calls apart
    task automatic apb(input logic w, input logic [17:0] addr, input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= addr;
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
        apb(1'b1, {idx, 2'h0}, wd);
    endtask

    task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
        apb(1'b0, {idx, 2'h0}, 8'h00);
        check({24'h0, rd}, {24'h0, exp});
        check({31'h0, err}, 32'h0);
    endtask

    // Bounded wait for the interrupt line
    task automatic wait_irq(output int n);
        n = 0;
        while (irq !== 1'b1 && n < 400) begin
            @(posedge pclk);
            n++;
        end
    endtask

    task automatic t_reset();
        rdc(`TMR_IDX_MODE, `TMR_RST_MODE);
        rdc(`TMR_IDX_RUN, 8'h00);
        rdc(`TMR_IDX_IRQ_STAT, 8'h00);
        wr(`TMR_IDX_CAP0_LO, 8'h55);
        rdc(`TMR_IDX_CAP0_LO, 8'h00);
        wr(`TMR_IDX_CMP0_LO, 8'h5a);
        rdc(`TMR_IDX_CMP0_LO, 8'h00);
        apb(1'b0, {16'h1181, 2'h0}, 8'h00);
        check({31'h0, err}, 32'h1);
        check({24'h0, rd}, 32'h0);
        // Misaligned and out-of-range accesses are refused and change nothing
        apb(1'b1, {`TMR_IDX_RUN, 2'h2}, 8'h05);
        check({31'h0, err}, 32'h1);
        apb(1'b0, {`TMR_IDX_MODE, 2'h1}, 8'h00);
        check({31'h0, err}, 32'h1);
        check({24'h0, rd}, 32'h0);
        apb(1'b1, {16'h1200, 2'h0}, 8'h00);
        check({31'h0, err}, 32'h1);
        rdc(`TMR_IDX_RUN, 8'h00);
    endtask

    // Match0 at count zero shows when the first tap arrives; 0 means stopped
    task automatic t_tap(input logic [1:0] sel, input int n);
        int c;
        wr(`TMR_IDX_IRQ_MASK, 8'h02);
        wr(`TMR_IDX_CMP0_LO, 8'h00);
        wr(`TMR_IDX_CMP0_HI, 8'h00);
        wr(`TMR_IDX_CMP1_LO, 8'hff);
        wr(`TMR_IDX_CMP1_HI, 8'hff);
        wr(`TMR_IDX_MODE, 8'h30 | sel);
        wr(`TMR_IDX_IRQ_STAT, 8'h07);
        wr(`TMR_IDX_RUN, 8'h05);
        wait_irq(c);
        check(32'(sel == 0 ? c == 400 : c >= n - 1 && c <= n + 3), 32'h1);
        wr(`TMR_IDX_MODE, 8'h10 | sel);
        rdc(`TMR_IDX_CAP0_LO, sel == 0 ? 8'h00 : 8'h01);
        rdc(`TMR_IDX_IRQ_STAT, sel == 0 ? 8'h00 : 8'h02);
        wr(`TMR_IDX_IRQ_MASK, 8'h00);
        #1 check({31'h0, irq}, 32'h0);
        wr(`TMR_IDX_IRQ_STAT, 8'h02);
        rdc(`TMR_IDX_IRQ_STAT, 8'h00);
        wr(`TMR_IDX_RUN, 8'h00);
    endtask

    // Clear on compare1 gives a period of compare1 + 1 taps
    task automatic t_clear();
        int c;
        int t0;
        wr(`TMR_IDX_IRQ_MASK, 8'h04);
        wr(`TMR_IDX_CMP0_LO, 8'hff);
        wr(`TMR_IDX_CMP0_HI, 8'hff);
        wr(`TMR_IDX_CMP1_LO, 8'h02);
        wr(`TMR_IDX_CMP1_HI, 8'h00);
        wr(`TMR_IDX_MODE, 8'h35);
        wr(`TMR_IDX_IRQ_STAT, 8'h07);
        wr(`TMR_IDX_RUN, 8'h05);
        wait_irq(c);
        t0 = cycles;
        wr(`TMR_IDX_IRQ_STAT, 8'h04);
        // Let the clear settle so the old level is not taken as a new event
        @(posedge pclk);
        wait_irq(c);
        check(cycles - t0, 32'd48);
        wr(`TMR_IDX_RUN, 8'h00);
    endtask

    // Flip-flop commands seen on the shared pin, then plain port use
    task automatic t_ff();
        logic [7:0] cmd [3] = '{8'h01, 8'h02, 8'h00};
        logic       exp [3] = '{1'b1, 1'b0, 1'b1};
        port_func_sel <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            wr(`TMR_IDX_FFCR, cmd[i]);
            repeat (2) @(posedge pclk);
            check({31'h0, shared_port_bit}, {31'h0, exp[i]});
            check({31'h0, shared_port_bit_oe}, 32'h1);
        end
        rdc(`TMR_IDX_FFCR, 8'h03);
        port_func_sel <= 1'b0;
        port_data <= 1'b1;
        repeat (2) @(posedge pclk);
        check({30'h0, shared_port_bit, shared_port_bit_oe}, 32'h2);
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, port_func_sel, port_data, port_dir} = 6'h00;
        paddr = 18'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        num_errors = 0;
        compares = 0;
        cycles = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        for (int s = 0; s < 4; s++)
            t_tap(2'(s), 4 << (2 * s));
        // A partial prescaler run must be wiped by stopping it
        wr(`TMR_IDX_RUN, 8'h04);
        repeat (10) @(posedge pclk);
        wr(`TMR_IDX_RUN, 8'h00);
        t_tap(2'h1, 16);
        t_clear();
        t_ff();
        test_done();
    end
endmodule
